// ===== inc/rss_opt_if.sv
// Interface between the sequencer and its option-load counter.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface rss_opt_if;
    logic       clr;
    logic       tick;
    logic [3:0] count;
    logic       done;
    modport ctl (output clr, output tick, input count, input done);
    modport cnt (input clr, input tick, output count, output done);
endinterface : rss_opt_if

// ===== inc/rss_pkg.sv
// Package for the reset start sequencer: option area, counts and states.
// Assumes a single 100 MHz core clock and an instruction-cycle tick derived from it.
package rss_pkg;
    localparam int          ADDR_W        = 14;
    localparam int          OPT_WORDS     = 16;
    localparam logic [13:0] OPT_BASE      = 14'h3ff0;
    localparam logic [13:0] OPT_LAST      = 14'h3fff;
    localparam logic [13:0] PC_START      = 14'h0000;
    localparam int          CFG_CYCLES    = 9;
    localparam int          EXT_HOLD_CYC  = 3;
    localparam int          CLK_PER_ICYC  = 4;
    localparam int          CNT_W         = 4;
    localparam logic [3:0]  CNT_RESET     = 4'h0;

    typedef enum logic [1:0] {
        RSS_RESET = 2'b00,
        RSS_CFG   = 2'b01,
        RSS_RUN   = 2'b11,
        RSS_HOLD  = 2'b10
    } rss_state_t;
endpackage : rss_pkg

// ===== logic/rss_cycle_counter.sv
// Instruction-cycle counter for the option configuration interval.
// Assumes clr and tick are synchronous to ref_clk.
`timescale 1ns/1ps
module rss_cycle_counter #(
    parameter int LIMIT = rss_pkg::CFG_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    rss_opt_if.cnt    bus
);
    import rss_pkg::*;

    if (LIMIT < 1 || LIMIT > (1 << CNT_W) - 1) begin : g_bad_limit
        $error("LIMIT must fit the counter");
    end

    logic [CNT_W-1:0] count_reg;
    wire              at_limit = (count_reg == CNT_W'(LIMIT));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= CNT_RESET;
        end else if (clk_en) begin
            if (bus.clr) begin
                count_reg <= CNT_RESET;
            end else if (bus.tick && !at_limit) begin
                count_reg <= count_reg + 4'h1;
            end
        end
    end

    assign bus.count = count_reg;
    assign bus.done  = at_limit;
endmodule : rss_cycle_counter

// ===== logic/rss_sequencer.sv
// Reset-release and hold-exit sequencer for a 4-bit controller core.
// Assumes reset_in_n and hold_in come from pins; the option ROM answers in the same cycle as opt_rd.
`timescale 1ns/1ps

// Contract
// - After reset rises, the first 9 instruction cycles load port driver types from options.
// - Only after that interval is the program counter set to zero and fetching started.
// - While reset is low every port driver is forced to open drain.
// - Options are read from the option area at 3ff0h to 3fffh, only its first four words at 3ff0h to 3ff3h.
// - Reset driven low during hold leaves the device in hold.
module rss_sequencer #(
    parameter int PORTS = 16
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire logic                  reset_in_n,
    input  wire logic                  hold_in,
    input  wire logic [7:0]            opt_data,
    output logic [rss_pkg::ADDR_W-1:0] opt_addr,
    output logic                       opt_rd,
    output logic [PORTS-1:0]           port_od,
    output logic [rss_pkg::ADDR_W-1:0] pc_load,
    output logic                       pc_load_en,
    output logic                       run,
    output logic                       hold_mode
);
    import rss_pkg::*;

    if (PORTS < 1 || PORTS > 8 * (OPT_WORDS / 4)) begin : g_bad_ports
        $error("PORTS out of range");
    end

    logic [1:0]       rst_sync_reg;
    logic [1:0]       hold_sync_reg;
    logic [1:0]       div_reg;
    rss_state_t       state_reg;
    rss_state_t       state_next;
    logic [PORTS-1:0] opt_od_reg;
    logic [ADDR_W-1:0] opt_addr_reg;
    logic             opt_rd_reg;
    logic [PORTS-1:0] port_od_reg;
    logic             pc_load_en_reg;
    logic             run_reg;
    logic             hold_reg;

    rss_opt_if cnt_bus ();

    rss_cycle_counter #(.LIMIT(CFG_CYCLES)) u_cnt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .bus     (cnt_bus)
    );

    wire ext_rst_low = !rst_sync_reg[1];
    wire ext_hold    = !hold_sync_reg[1];
    wire icyc_tick   = (div_reg == 2'(CLK_PER_ICYC - 1));
    wire in_cfg      = (state_reg == RSS_CFG);
    wire [3:0] idx   = cnt_bus.count;

    assign cnt_bus.clr  = ext_rst_low || (state_reg == RSS_RESET);
    assign cnt_bus.tick = in_cfg && icyc_tick;

    // Hold input is active low: hold_in low enters hold
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RSS_RESET: if (!ext_rst_low && !ext_hold) state_next = RSS_CFG;
            RSS_CFG: begin
                if (ext_rst_low)       state_next = RSS_RESET;
                else if (cnt_bus.done) state_next = RSS_RUN;
            end
            RSS_RUN: begin
                if (ext_hold)         state_next = RSS_HOLD;
                else if (ext_rst_low) state_next = RSS_RESET;
            end
            RSS_HOLD: begin
                // Reset alone does not end hold; hold must rise first
                if (!ext_hold && ext_rst_low) state_next = RSS_RESET;
            end
        endcase
    end

    // Each option word carries driver types for eight ports, bit set = open drain
    wire [ADDR_W-1:0] addr_next = OPT_BASE + {{(ADDR_W-4){1'b0}}, idx};

    // Next-value selection for the registers below
    wire [1:0]        div_next  = (in_cfg && !icyc_tick) ? div_reg + 2'b01 : 2'b00;
    wire              go_run    = (state_next == RSS_RUN);
    wire              go_hold   = (state_next == RSS_HOLD);
    wire              rd_next   = in_cfg && icyc_tick && (idx < 4'(OPT_WORDS / 4));
    wire [ADDR_W-1:0] addr_sel  = in_cfg ? addr_next : OPT_BASE;
    wire [PORTS-1:0]  od_next   = (ext_rst_low || !go_run) ? '1 : opt_od_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg  <= 2'b00;
            hold_sync_reg <= 2'b11;
        end else begin
            rst_sync_reg  <= {rst_sync_reg[0], reset_in_n};
            hold_sync_reg <= {hold_sync_reg[0], hold_in};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg   <= 2'b00;
            state_reg <= RSS_RESET;
        end else if (clk_en) begin
            div_reg   <= div_next;
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_addr_reg <= OPT_BASE;
            opt_rd_reg   <= 1'b0;
        end else if (clk_en) begin
            opt_rd_reg   <= rd_next;
            opt_addr_reg <= addr_sel;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_od_reg <= '1;
        end else if (clk_en && opt_rd_reg) begin
            for (int b = 0; b < 8; b++) begin
                if ((int'(opt_addr_reg[3:0]) * 8 + b) < PORTS)
                    opt_od_reg[(int'(opt_addr_reg[3:0]) * 8 + b) % PORTS] <= opt_data[b];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_od_reg    <= '1;
            pc_load_en_reg <= 1'b0;
            run_reg        <= 1'b0;
            hold_reg       <= 1'b0;
        end else if (clk_en) begin
            port_od_reg    <= od_next;
            pc_load_en_reg <= in_cfg && go_run;
            run_reg        <= go_run;
            hold_reg       <= go_hold;
        end
    end

    assign opt_addr   = opt_addr_reg;
    assign opt_rd     = opt_rd_reg;
    assign port_od    = port_od_reg;
    assign pc_load    = PC_START;
    assign pc_load_en = pc_load_en_reg;
    assign run        = run_reg;
    assign hold_mode  = hold_reg;

    // Start sequence, option reads and hold state
    a_od_in_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && ext_rst_low |=> port_od == '1)
        else $error("ports not open drain during reset");
    a_pc_after_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pc_load_en |-> $past(cnt_bus.count) == 4'(CFG_CYCLES))
        else $error("program counter loaded early");
    a_hold_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == RSS_HOLD && ext_hold |=> state_reg == RSS_HOLD)
        else $error("hold left while hold input low");
    a_cfg_length: assert property (@(posedge ref_clk) disable iff (!rst_n || ext_rst_low)
        $rose(in_cfg) && clk_en |-> in_cfg [*8])
        else $error("configuration interval too short");
    a_opt_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
        opt_rd |-> opt_addr >= OPT_BASE && opt_addr <= OPT_LAST)
        else $error("option read outside option area");
    a_cnt_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && ext_rst_low |=> cnt_bus.count == CNT_RESET)
        else $error("cycle counter not cleared in reset");
    a_run_no_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && ext_rst_low |=> !run)
        else $error("running while in reset");
    a_hold_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hold_mode && !ext_rst_low |=> hold_mode)
        else $error("hold left without reset");

    a_pc_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && pc_load_en |=> !pc_load_en)
        else $error("start pulse longer than one cycle");
    a_run_with_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pc_load_en |-> run)
        else $error("start pulse without run");
    a_no_run_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_cfg |-> !run)
        else $error("running during configuration");
    a_rd_not_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
        opt_rd |-> !run)
        else $error("option read while running");
    a_cnt_reset_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && state_reg == RSS_RESET |=> cnt_bus.count == CNT_RESET)
        else $error("cycle counter not cleared before configuration");
    a_start_from_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(run) |-> $past(in_cfg))
        else $error("run started without configuration");
    a_cfg_from_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(in_cfg) |-> $past(state_reg) == RSS_RESET)
        else $error("configuration entered from wrong state");

    a_rd_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && opt_rd |=> !opt_rd)
        else $error("option reads back to back");
    a_od_until_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !run |-> port_od == '1)
        else $error("optioned drivers before start");
    a_run_hold_excl: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(run && hold_mode))
        else $error("run and hold together");
    a_hold_no_od: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hold_mode |-> port_od == '1)
        else $error("optioned drivers in hold");
    a_addr_base: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && !in_cfg |=> opt_addr == OPT_BASE)
        else $error("option address not parked");
endmodule : rss_sequencer

// ===== test/reset_start_sequencer_tb_top.sv
// Bench for the reset start sequencer: start, abort in configuration, hold.
// Assumes rss_ctl_model drives the pins and answers option reads.
`timescale 1ns/1ps
module reset_start_sequencer_tb_top;
    import rss_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst_n   = 1'b0;
    logic              clk_en  = 1'b1;
    logic              reset_in_n, hold_in, opt_rd, pc_load_en, run, hold_mode;
    logic [7:0]        opt_data;
    logic [13:0]       opt_addr, pc_load;
    logic [15:0]       port_od;
    int                n_fail = 0;
    int                checks = 0;
    int                n_rd   = 0;
    always #5 ref_clk = ~ref_clk;
    rss_ctl_model model (.ref_clk(ref_clk), .opt_addr(opt_addr), .opt_rd(opt_rd),
        .reset_in_n(reset_in_n), .hold_in(hold_in), .opt_data(opt_data));
    rss_sequencer #(.PORTS(16)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reset_in_n(reset_in_n), .hold_in(hold_in), .opt_data(opt_data),
        .opt_addr(opt_addr), .opt_rd(opt_rd), .port_od(port_od), .pc_load(pc_load),
        .pc_load_en(pc_load_en), .run(run), .hold_mode(hold_mode));
    task automatic tally_and_finish;
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    task automatic cmp1(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : cmp1
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h", $time, msg, got);
        end
    endtask : cmp16
    // Every option read stays inside the option area
    always @(negedge ref_clk) begin
        if (opt_rd === 1'b1) begin
            n_rd++;
            cmp1(opt_addr >= OPT_BASE && opt_addr <= OPT_LAST, 1'b1, "option address");
        end
    end
    task automatic t_start;
        int n;
        n = 0;
        n_rd = 0;
        model.set_pins(1'b1, 1'b1);
        while (n < 60) begin
            @(negedge ref_clk);
            n++;
            if (pc_load_en === 1'b1) break;
            cmp1(run, 1'b0, "run during configuration");
        end
        // Two synchroniser clocks, one state clock and one output register on top
        cmp1(n > CFG_CYCLES * CLK_PER_ICYC && n <= CFG_CYCLES * CLK_PER_ICYC + 5, 1'b1,
            "configuration length");
        cmp16({2'h0, pc_load}, {2'h0, PC_START}, "start address");
        cmp1(n_rd >= 2, 1'b1, "option words read");
        @(negedge ref_clk);
        cmp1(run, 1'b1, "run after start");
        cmp1(pc_load_en, 1'b0, "single start pulse");
        cmp16(port_od, 16'h3ca5, "optioned driver types");
    endtask : t_start
    task automatic t_reset_low;
        model.set_pins(1'b0, 1'b1);
        repeat (4) @(negedge ref_clk);
        cmp16(port_od, 16'hffff, "open drain in reset");
        cmp1(run, 1'b0, "no run in reset");
    endtask : t_reset_low
    task automatic t_abort_cfg;
        model.set_pins(1'b1, 1'b1);
        repeat (10) @(negedge ref_clk);
        t_reset_low();
        repeat (40) begin
            @(negedge ref_clk);
            cmp1(pc_load_en, 1'b0, "no start after abort");
        end
    endtask : t_abort_cfg
    task automatic t_hold;
        model.set_pins(1'b1, 1'b0);
        repeat (8) @(negedge ref_clk);
        cmp1(hold_mode, 1'b1, "hold entered");
        model.set_pins(1'b0, 1'b0);
        repeat (20) @(negedge ref_clk);
        cmp1(hold_mode, 1'b1, "hold kept in reset");
        cmp16(port_od, 16'hffff, "open drain in hold reset");
        model.set_pins(1'b0, 1'b1);
        repeat (8) @(negedge ref_clk);
        t_start();
        cmp1(hold_mode, 1'b0, "hold left");
    endtask : t_hold
    // Configuration pauses while clk_en is low and resumes where it stopped
    task automatic t_freeze;
        int m;
        m = 0;
        model.set_pins(1'b1, 1'b1);
        repeat (12) @(negedge ref_clk);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (20) begin
            @(negedge ref_clk);
            cmp1(pc_load_en, 1'b0, "start while frozen");
        end
        @(posedge ref_clk);
        clk_en <= 1'b1;
        while (m < 60) begin
            @(negedge ref_clk);
            m++;
            if (pc_load_en === 1'b1) break;
        end
        // Forty enabled clocks from pin rise to start, twelve spent before the pause
        cmp1(m >= CFG_CYCLES * CLK_PER_ICYC - 9 && m <= CFG_CYCLES * CLK_PER_ICYC - 5, 1'b1,
            "start after pause");
        @(negedge ref_clk);
        cmp1(run, 1'b1, "run after pause");
    endtask : t_freeze
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (16) @(posedge ref_clk);
        t_reset_low();
        t_start();
        t_reset_low();
        t_abort_cfg();
        t_start();
        t_hold();
        t_reset_low();
        t_freeze();
        tally_and_finish();
    end
endmodule : reset_start_sequencer_tb_top

// ===== test/rss_ctl_model.sv
// Model of the outside reset and hold circuit and of the option words.
// Assumes the bench calls set_pins from its main process on ref_clk.
`timescale 1ns/1ps
module rss_ctl_model (
    input  wire logic        ref_clk,
    input  wire logic [13:0] opt_addr,
    input  wire logic        opt_rd,
    output logic             reset_in_n,
    output logic             hold_in,
    output logic [7:0]       opt_data
);
    logic [7:0] word;
    initial begin
        reset_in_n = 1'b0;
        hold_in    = 1'b1;
    end
    // Words 0 and 1 carry driver types, the rest of the area is zero
    assign word = (opt_addr == 14'h3ff0) ? 8'ha5 : (opt_addr == 14'h3ff1) ? 8'h3c : 8'h00;
    // Outside a read the lines show the inverse, never the last value
    assign opt_data = opt_rd ? word : ~word;
    task automatic set_pins(input logic r, input logic h);
        @(posedge ref_clk);
        reset_in_n <= r;
        hold_in    <= h;
    endtask : set_pins
endmodule : rss_ctl_model
